// [lppw_port.sv]
// Parallel host port of the display controller
`timescale 1ns/100ps
module lppw_port (
  // System
  input wire logic clk,
  input wire logic reset_n,
  // Host pins
  input wire logic ext_reset_n,
  input wire logic port_select_n,
  input wire logic data_cmd_sel,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [lppw_pkg::BUS_W-1:0] data_in,
  output logic [lppw_pkg::BUS_W-1:0] data_out,
  output logic data_oe_n,
  // Status to display side
  output logic [lppw_pkg::ADDR_W-1:0] pixel_addr,
  output logic [7:0] last_cmd
);
  localparam int AW = lppw_pkg::ADDR_W;
  logic rst_ok;
  logic cs_s;
  logic dc_s;
  logic wr_s;
  logic rd_s;
  logic wr_d_r;
  logic rd_d_r;
  logic wr_rise;
  logic rd_rise;
  logic rd_fall;
  logic ereset_s;
  logic [7:0] bus_s1_r;
  logic [7:0] bus_s2_r;
  logic [7:0] cmd_r;
  logic [7:0] scan_r;
  logic [2:0] parm_r;
  logic [8:0] col_lo_r;
  logic [8:0] col_hi_r;
  logic [8:0] row_lo_r;
  logic [8:0] row_hi_r;
  logic [8:0] col_r;
  logic [8:0] row_r;
  logic [7:0] hi_byte_r;
  logic [7:0] par_hi_r;
  lppw_pkg::lppw_byte_t bsel_r;
  logic mem_we;
  logic [15:0] mem_wd;
  logic [15:0] mem_rd;
  logic [AW-1:0] addr;
  logic col_end;
  logic row_end;
  logic rd_half_r;

  // Pin synchronisers
  lppw_sync #(.INIT(1'b1)) u_cs (.clk(clk), .reset_n(reset_n),
    .pin(port_select_n), .level(cs_s));
  lppw_sync #(.INIT(1'b0)) u_dc (.clk(clk), .reset_n(reset_n),
    .pin(data_cmd_sel), .level(dc_s));
  lppw_sync #(.INIT(1'b1)) u_wr (.clk(clk), .reset_n(reset_n),
    .pin(write_strobe_n), .level(wr_s));
  lppw_sync #(.INIT(1'b1)) u_rd (.clk(clk), .reset_n(reset_n),
    .pin(read_strobe_n), .level(rd_s));
  lppw_sync #(.INIT(1'b0)) u_er (.clk(clk), .reset_n(reset_n),
    .pin(ext_reset_n), .level(ereset_s));

  // Port registers held while either reset is low; bus delay and frame memory run on
  assign rst_ok = reset_n && ereset_s;

  // Data bus delayed two cycles; the strobe filter takes four
  always_ff @(posedge clk) begin
    bus_s1_r <= data_in;
    bus_s2_r <= bus_s1_r;
  end

  // Strobe edge detection on filtered levels
  always_ff @(posedge clk) begin
    if (!rst_ok) begin
      wr_d_r <= 1'b1;
      rd_d_r <= 1'b1;
    end else begin
      wr_d_r <= wr_s;
      rd_d_r <= rd_s;
    end
  end
  assign wr_rise = !cs_s && wr_s && !wr_d_r;
  assign rd_rise = !cs_s && rd_s && !rd_d_r;
  assign rd_fall = !cs_s && !rd_s && rd_d_r;

  // Command latch and parameter counter
  always_ff @(posedge clk) begin
    if (!rst_ok) begin
      cmd_r <= 8'h00;
      parm_r <= 3'h0;
      par_hi_r <= 8'h00;
      scan_r <= lppw_pkg::SCAN_RST;
      col_lo_r <= 9'h000;
      col_hi_r <= 9'(lppw_pkg::COLS - 1);
      row_lo_r <= 9'h000;
      row_hi_r <= 9'(lppw_pkg::ROWS - 1);
    end else if (wr_rise && !dc_s) begin
      cmd_r <= bus_s2_r;
      parm_r <= 3'h0;
    end else if (wr_rise && dc_s && cmd_r != lppw_pkg::CMD_MEM_WR) begin
      parm_r <= parm_r + 3'h1;
      par_hi_r <= bus_s2_r;
      case (cmd_r)
        lppw_pkg::CMD_COL_SET: begin
          if (parm_r == 3'h1) col_lo_r <= {par_hi_r[0], bus_s2_r};
          if (parm_r == 3'h3) col_hi_r <= {par_hi_r[0], bus_s2_r};
        end
        lppw_pkg::CMD_ROW_SET: begin
          if (parm_r == 3'h1) row_lo_r <= {par_hi_r[0], bus_s2_r};
          if (parm_r == 3'h3) row_hi_r <= {par_hi_r[0], bus_s2_r};
        end
        lppw_pkg::CMD_SCAN: begin
          if (parm_r == 3'h0) scan_r <= bus_s2_r;
        end
        default: begin
        end
      endcase
    end
  end
  assign last_cmd = cmd_r;

  // Byte pairing into pixels, high byte first
  always_ff @(posedge clk) begin
    if (!rst_ok) begin
      bsel_r <= lppw_pkg::LPPW_IDLE;
      hi_byte_r <= 8'h00;
    end else if (wr_rise && !dc_s) begin
      bsel_r <= lppw_pkg::LPPW_HIGH;
    end else if (wr_rise && cmd_r == lppw_pkg::CMD_MEM_WR) begin
      case (bsel_r)
        lppw_pkg::LPPW_HIGH: begin
          hi_byte_r <= bus_s2_r;
          bsel_r <= lppw_pkg::LPPW_LOW;
        end
        lppw_pkg::LPPW_LOW: bsel_r <= lppw_pkg::LPPW_HIGH;
        default: bsel_r <= lppw_pkg::LPPW_HIGH;
      endcase
    end
  end
  assign mem_we = wr_rise && dc_s && cmd_r == lppw_pkg::CMD_MEM_WR &&
                  bsel_r == lppw_pkg::LPPW_LOW;
  assign mem_wd = {hi_byte_r, bus_s2_r};

  // Window address stepping; direction from scan mode
  assign col_end = scan_r[lppw_pkg::SCAN_COL_DEC] ? (col_r == col_lo_r)
                                                  : (col_r == col_hi_r);
  assign row_end = scan_r[lppw_pkg::SCAN_ROW_DEC] ? (row_r == row_lo_r)
                                                  : (row_r == row_hi_r);
  always_ff @(posedge clk) begin
    if (!rst_ok) begin
      col_r <= 9'h000;
      row_r <= 9'h000;
    end else if (wr_rise && !dc_s && (bus_s2_r == lppw_pkg::CMD_MEM_WR ||
                 bus_s2_r == lppw_pkg::CMD_MEM_RD)) begin
      col_r <= scan_r[lppw_pkg::SCAN_COL_DEC] ? col_hi_r : col_lo_r;
      row_r <= scan_r[lppw_pkg::SCAN_ROW_DEC] ? row_hi_r : row_lo_r;
    end else if (mem_we || (rd_rise && dc_s && rd_half_r
                 && cmd_r == lppw_pkg::CMD_MEM_RD)) begin
      if (!col_end) begin
        col_r <= scan_r[lppw_pkg::SCAN_COL_DEC] ? col_r - 9'h1
                                                : col_r + 9'h1;
      end else begin
        col_r <= scan_r[lppw_pkg::SCAN_COL_DEC] ? col_hi_r : col_lo_r;
        if (!row_end) begin
          row_r <= scan_r[lppw_pkg::SCAN_ROW_DEC] ? row_r - 9'h1
                                                  : row_r + 9'h1;
        end else begin
          row_r <= scan_r[lppw_pkg::SCAN_ROW_DEC] ? row_hi_r : row_lo_r;
        end
      end
    end
  end
  assign addr = AW'(row_r) * AW'(lppw_pkg::COLS) + AW'(col_r);
  assign pixel_addr = addr;

  // Frame memory, 76800 pixels of two bytes
  lppw_frame_mem #(.DEPTH(lppw_pkg::PIXELS)) u_mem (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr(addr),
    .wr_data(mem_wd),
    .rd_addr(addr),
    .rd_data(mem_rd)
  );

  // Read side pairing toggle and bus drive
  always_ff @(posedge clk) begin
    if (!rst_ok || (wr_rise && !dc_s)) begin
      rd_half_r <= 1'b0;
    end else if (rd_rise && dc_s) begin
      rd_half_r <= !rd_half_r;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_ok) begin
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else if (rd_fall) begin
      data_oe_n <= 1'b0;
      data_out <= (cmd_r != lppw_pkg::CMD_MEM_RD) ? cmd_r :
                  rd_half_r ? mem_rd[7:0] : mem_rd[15:8];
    end else if (rd_s || cs_s) begin
      data_oe_n <= 1'b1;
    end
  end

  // Drivers only on while a selected read is low
  drive_only_read_a: assert property (@(posedge clk) disable iff (!rst_ok)
    !data_oe_n |-> !$past(rd_s) && !$past(cs_s))
    else $error("bus driven outside a read");
  // Drivers off one cycle after strobe rises
  drive_release_a: assert property (@(posedge clk) disable iff (!rst_ok)
    rd_rise |=> data_oe_n)
    else $error("bus still driven after read");
  // Read fall turns drivers on next cycle
  drive_on_a: assert property (@(posedge clk) disable iff (!rst_ok)
    rd_fall |=> !data_oe_n)
    else $error("read not driven");
  // Unselected strobes change nothing
  cs_gate_a: assert property (@(posedge clk) disable iff (!rst_ok)
    cs_s |=> $stable(cmd_r) && $stable(col_r))
    else $error("state changed while deselected");
  // Command byte latched from bus
  cmd_latch_a: assert property (@(posedge clk) disable iff (!rst_ok)
    wr_rise && !dc_s |=> cmd_r == $past(bus_s2_r))
    else $error("command not latched");
  // Pixel write carries high byte first
  sequence pix_pair_s;
    wr_rise && dc_s && cmd_r == lppw_pkg::CMD_MEM_WR &&
      bsel_r == lppw_pkg::LPPW_HIGH;
  endsequence
  pix_order_a: assert property (@(posedge clk) disable iff (!rst_ok)
    pix_pair_s |=> bsel_r == lppw_pkg::LPPW_LOW &&
      hi_byte_r == $past(bus_s2_r))
    else $error("high byte not held");
  // Column steps up by one on each pixel short of the window edge in increment scan
  col_step_a: assert property (@(posedge clk) disable iff (!rst_ok)
    mem_we && !col_end && !scan_r[lppw_pkg::SCAN_COL_DEC]
      |=> col_r == $past(col_r) + 9'h1)
    else $error("column not stepped");
  // External reset holds command cleared
  ext_reset_a: assert property (@(posedge clk)
    reset_n && !ereset_s |=> cmd_r == 8'h00)
    else $error("external reset ignored");
  // Column counts down in decrement scan
  col_dec_a: assert property (@(posedge clk) disable iff (!rst_ok)
    mem_we && !col_end && scan_r[lppw_pkg::SCAN_COL_DEC]
      |=> col_r == $past(col_r) - 9'h1)
    else $error("column not stepped down");
  // Row steps when a column span completes
  row_step_a: assert property (@(posedge clk) disable iff (!rst_ok)
    mem_we && col_end && !row_end && !scan_r[lppw_pkg::SCAN_ROW_DEC]
      |=> row_r == $past(row_r) + 9'h1)
    else $error("row not stepped");
  // Column reloads at the window edge
  col_wrap_a: assert property (@(posedge clk) disable iff (!rst_ok)
    mem_we && col_end |=> col_r ==
      (scan_r[lppw_pkg::SCAN_COL_DEC] ? col_hi_r : col_lo_r))
    else $error("column not reloaded");
  // Memory write command loads window start
  write_start_a: assert property (@(posedge clk) disable iff (!rst_ok)
    wr_rise && !dc_s && bus_s2_r == lppw_pkg::CMD_MEM_WR |=> col_r ==
      (scan_r[lppw_pkg::SCAN_COL_DEC] ? col_hi_r : col_lo_r))
    else $error("window start not loaded");
  // Paused read strobe keeps the byte
  read_pause_a: assert property (@(posedge clk) disable iff (!rst_ok)
    !cs_s && !rd_s && !rd_fall |=> $stable(data_out))
    else $error("read byte changed during pause");
  // Command restarts parameter count
  param_clear_a: assert property (@(posedge clk) disable iff (!rst_ok)
    wr_rise && !dc_s |=> parm_r == 3'h0)
    else $error("parameter count not cleared");
  // Data bytes leave the command alone
  cmd_hold_a: assert property (@(posedge clk) disable iff (!rst_ok)
    wr_rise && dc_s |=> $stable(cmd_r))
    else $error("data byte taken as command");
  // Non-memory read returns the command
  read_cmd_a: assert property (@(posedge clk) disable iff (!rst_ok)
    rd_fall && cmd_r != lppw_pkg::CMD_MEM_RD |=> data_out == $past(cmd_r))
    else $error("read byte not the command");
  // Reset keeps drivers off and command clear
  reset_quiet_a: assert property (@(posedge clk)
    !rst_ok |=> data_oe_n && cmd_r == 8'h00)
    else $error("reset did not quiet the port");
  // Deselected port keeps row and scan mode
  sel_hold_a: assert property (@(posedge clk) disable iff (!rst_ok)
    cs_s |=> $stable(row_r) && $stable(scan_r))
    else $error("row or scan changed while deselected");
  // Command restarts both byte pairings
  pair_reset_a: assert property (@(posedge clk) disable iff (!rst_ok)
    wr_rise && !dc_s |=> bsel_r == lppw_pkg::LPPW_HIGH && !rd_half_r)
    else $error("byte pairing not restarted");
  // Each data read flips the byte half
  read_half_a: assert property (@(posedge clk) disable iff (!rst_ok)
    rd_rise && dc_s |=> rd_half_r != $past(rd_half_r))
    else $error("read half not toggled");
  // Low byte of a pixel read completes
  sequence rd_lo_done_s;
    rd_rise && dc_s && rd_half_r && cmd_r == lppw_pkg::CMD_MEM_RD &&
      !col_end && !scan_r[lppw_pkg::SCAN_COL_DEC];
  endsequence
  read_step_a: assert property (@(posedge clk) disable iff (!rst_ok)
    rd_lo_done_s |=> col_r == $past(col_r) + 9'h1)
    else $error("read did not step column");
endmodule : lppw_port

// [lppw_pkg.sv]
// Package: constants for the parallel display host port
// How it works
// - Port select low enables transfers
// - External reset low resets logic
// - Select low means command, high data
// - Byte captured at write strobe rising edge
// - Drive read data while read strobe low
// - Read strobe may pause any time
// - Data bus is eight bits wide
// - Pixels are sixteen bit five-six-five
// - Address steps rows, columns per scan mode
// - Frame memory holds 153600 bytes
package lppw_pkg;
  localparam int BUS_W = 8;
  localparam int PIX_W = 16;
  localparam int COLS = 240;
  localparam int ROWS = 320;
  localparam int FRAME_BYTES = 172800;
  localparam int PIXELS = COLS * ROWS;
  localparam int ADDR_W = 17;
  localparam int SYNC_STAGES = 3;
  // Command codes (chosen)
  localparam logic [7:0] CMD_COL_SET = 8'h2A;
  localparam logic [7:0] CMD_ROW_SET = 8'h2B;
  localparam logic [7:0] CMD_MEM_WR = 8'h2C;
  localparam logic [7:0] CMD_SCAN = 8'h36;
  localparam logic [7:0] CMD_MEM_RD = 8'h2E;
  // Scan mode field positions
  localparam int SCAN_ROW_DEC = 7;
  localparam int SCAN_COL_DEC = 6;
  localparam logic [7:0] SCAN_RST = 8'h00;
  typedef enum logic [1:0] {
    LPPW_IDLE = 2'b00,
    LPPW_HIGH = 2'b01,
    LPPW_LOW = 2'b11
  } lppw_byte_t;
endpackage : lppw_pkg

// [lppw_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module lppw_sync #(
  parameter logic INIT = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // Shift chain; s1 feeds only s2
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Level changes once second and third agree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      level <= INIT;
    end else if (s2_r == s3_r) begin
      level <= s3_r;
    end
  end
endmodule : lppw_sync

// [lppw_frame_mem.sv]
// Frame memory, 16-bit pixel words
`timescale 1ns/100ps
module lppw_frame_mem #(
  parameter int DEPTH = lppw_pkg::PIXELS
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [lppw_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [lppw_pkg::PIX_W-1:0] wr_data,
  // Read port
  input wire logic [lppw_pkg::ADDR_W-1:0] rd_addr,
  output logic [lppw_pkg::PIX_W-1:0] rd_data
);
  logic [lppw_pkg::PIX_W-1:0] mem [DEPTH];
  // Synchronous write and read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : lppw_frame_mem

// [lppw_host.sv]
// Host model that drives the parallel strobe port
`timescale 1ns/100ps
module lppw_host (
  // Clock
  input wire logic clk,
  // Host pins
  output logic ext_reset_n,
  output logic port_select_n,
  output logic data_cmd_sel,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic [7:0] host_data,
  // Bus level as seen by the host
  input wire logic [7:0] bus,
  input wire logic data_oe_n
);
  // Idle pins at time zero
  initial begin
    ext_reset_n = 1'b1;
    port_select_n = 1'b1;
    data_cmd_sel = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    host_data = 8'h00;
  end
  // Let clock edges pass
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // One byte write; sel low leaves chip select high
  task automatic wr(input logic dc, input logic sel, input logic [7:0] b);
    data_cmd_sel <= dc;
    tick(1);
    port_select_n <= ~sel;
    host_data <= b;
    tick(4);
    write_strobe_n <= 1'b0;
    tick(6);
    write_strobe_n <= 1'b1;
    tick(6);
    port_select_n <= 1'b1;
    tick(4);
  endtask : wr
  // One byte read, taken at the read strobe rising edge
  task automatic rd(output logic [7:0] b, output logic oe_n);
    port_select_n <= 1'b0;
    host_data <= ~host_data; // Released bus shows no stale byte
    tick(1);
    data_cmd_sel <= 1'b1;
    tick(1);
    read_strobe_n <= 1'b0;
    tick(9);
    b = bus;
    oe_n = data_oe_n;
    read_strobe_n <= 1'b1;
    tick(6);
    port_select_n <= 1'b1;
    tick(4);
  endtask : rd
  // Host reset pulse
  task automatic hreset();
    ext_reset_n <= 1'b0;
    tick(8);
    ext_reset_n <= 1'b1;
    tick(8);
  endtask : hreset
endmodule : lppw_host

// [lppw_port_tb.sv]
// Self-checking testbench for the parallel host port
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
  failures++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module lppw_port_tb;
  logic clk;
  logic reset_n;
  logic ext_reset_n, port_select_n, data_cmd_sel;
  logic write_strobe_n, read_strobe_n, data_oe_n;
  logic [7:0] host_data, data_out, bus, last_cmd, b;
  logic [16:0] pixel_addr;
  logic oe;
  int failures = 0;
  int tests_run = 0;
  // Bus level from both drivers
  assign bus = data_oe_n ? host_data : data_out;
  // Host model and design
  lppw_host host (.clk(clk), .ext_reset_n(ext_reset_n),
    .port_select_n(port_select_n), .data_cmd_sel(data_cmd_sel),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .host_data(host_data), .bus(bus), .data_oe_n(data_oe_n));
  lppw_port dut (.clk(clk), .reset_n(reset_n), .ext_reset_n(ext_reset_n),
    .port_select_n(port_select_n), .data_cmd_sel(data_cmd_sel),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .data_in(bus), .data_out(data_out), .data_oe_n(data_oe_n),
    .pixel_addr(pixel_addr), .last_cmd(last_cmd));
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // Window from column c and row r to the far corner
  task automatic window(input logic [7:0] c, input logic [7:0] r);
    logic [7:0] cp [4];
    logic [7:0] rp [4];
    cp = '{8'h00, c, 8'h00, 8'hEF};
    rp = '{8'h00, r, 8'h01, 8'h3F};
    host.wr(1'b0, 1'b1, lppw_pkg::CMD_COL_SET);
    foreach (cp[i]) host.wr(1'b1, 1'b1, cp[i]);
    host.wr(1'b0, 1'b1, lppw_pkg::CMD_ROW_SET);
    foreach (rp[i]) host.wr(1'b1, 1'b1, rp[i]);
  endtask : window
  // Idle outputs after reset
  task automatic t_reset();
    `CHK("oe_n", 1'b1, data_oe_n)
    `CHK("last_cmd", 8'h00, last_cmd)
    `CHK("addr", 17'h00000, pixel_addr)
  endtask : t_reset
  // Command then data byte, and strobes while unselected
  task automatic t_cmd();
    host.wr(1'b0, 1'b1, lppw_pkg::CMD_SCAN);
    `CHK("cmd", lppw_pkg::CMD_SCAN, last_cmd)
    host.wr(1'b1, 1'b1, 8'h00);
    `CHK("param", lppw_pkg::CMD_SCAN, last_cmd)
    host.wr(1'b0, 1'b0, 8'h5A);
    `CHK("unsel", lppw_pkg::CMD_SCAN, last_cmd)
    host.rd(b, oe);
    `CHK("rd_cmd", lppw_pkg::CMD_SCAN, b)
    `CHK("rd_oe", 1'b0, oe)
    host.tick(4);
    `CHK("oe_idle", 1'b1, data_oe_n)
  endtask : t_cmd
  // Two pixels written high byte first, then read back
  task automatic t_pixels();
    logic [7:0] px [4] = '{8'hA5, 8'h3C, 8'h0F, 8'hF0};
    window(8'h05, 8'h02);
    host.wr(1'b0, 1'b1, lppw_pkg::CMD_MEM_WR);
    foreach (px[i]) host.wr(1'b1, 1'b1, px[i]);
    window(8'h05, 8'h02);
    host.wr(1'b0, 1'b1, lppw_pkg::CMD_MEM_RD);
    foreach (px[i]) begin
      host.rd(b, oe);
      `CHK("pixel", px[i], b)
    end
    `CHK("addr_step", 17'h001E7, pixel_addr)
  endtask : t_pixels
  // Column-decrement scan: right to left, then next row
  task automatic t_scan();
    logic [7:0] px [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
    host.wr(1'b0, 1'b1, lppw_pkg::CMD_SCAN);
    host.wr(1'b1, 1'b1, 8'h40);
    window(8'hEE, 8'h02);
    host.wr(1'b0, 1'b1, lppw_pkg::CMD_MEM_WR);
    `CHK("scan_start", 17'h002CF, pixel_addr)
    host.wr(1'b1, 1'b1, px[0]);
    host.wr(1'b1, 1'b1, px[1]);
    `CHK("scan_col", 17'h002CE, pixel_addr)
    host.wr(1'b1, 1'b1, px[2]);
    host.wr(1'b1, 1'b1, px[3]);
    `CHK("scan_row", 17'h003BF, pixel_addr)
    window(8'hEE, 8'h02);
    host.wr(1'b0, 1'b1, lppw_pkg::CMD_MEM_RD);
    foreach (px[i]) begin
      host.rd(b, oe);
      `CHK("scan_pixel", px[i], b)
    end
  endtask : t_scan
  // Host reset clears the port
  task automatic t_ext_reset();
    host.hreset();
    `CHK("ext_rst", 8'h00, last_cmd)
    `CHK("ext_addr", 17'h00000, pixel_addr)
    `CHK("ext_oe", 1'b1, data_oe_n)
  endtask : t_ext_reset
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    results();
  end
  // Main sequence
  initial begin
    reset_n = 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_cmd();
    t_pixels();
    t_scan();
    t_ext_reset();
    results();
  end
endmodule : lppw_port_tb
